// File: logic/cwm_card_io_window_mapper.sv
`timescale 1ns/1ps
// Contract
// RULE1: Software keeps both windows off host ports 3E0h and 3E1h.
// RULE2: Window 0 fixed width bit: 0 is 8-bit path, 1 is 16-bit.
// RULE3: Window 0 auto-size on: width follows card -IOIS16 per access.
// RULE4: Window 0 timing select bit picks timing set 0 or 1.
// RULE5: Window 1 width bit 4 picks 8/16-bit while auto-size bit 5 clear.
// RULE6: Window 1 auto-size on: width follows card -IOIS16 per access.
// RULE7: Software sets window 1 auto-size for disk interface mode.
// RULE8: Window 1 timing select bit 7 picks timing set 0 or 1.
// RULE9: Forward only when start <= address <= end, both inclusive.
// RULE10: Start address is low byte bits 7:0 plus high byte 15:8.
// RULE11: End address is low byte bits 7:0 plus high byte 15:8.
// RULE12: Card address is host address plus even 16-bit window offset.
// RULE13: Software writes zero to offset low bit 0.
// RULE14: Two identical windows; offsets at 36h/37h and 38h/39h.
// RULE15: Window decodes only while its map enable bit 6 or 7 set.
// RULE16: No enabled window hit means no claim and no card access.
module cwm_card_io_window_mapper
    import cwm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_io_req,
    input  wire logic [15:0] host_io_addr,
    input  wire logic        card_iois16_n,
    output logic             host_claim,
    output logic             card_io_req,
    output logic      [15:0] card_io_addr,
    output logic             card_io_16bit,
    output logic             card_io_timing,
    output logic             card_io_win
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Address is qualified by the synced request; ISA holds it stable
    logic        req_meta_reg;
    logic        req_sync_reg;
    logic [15:0] addr_meta_reg;
    logic [15:0] addr_sync_reg;
    logic        iois_meta_reg;
    logic        iois_sync_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            req_meta_reg  <= 1'b0;
            req_sync_reg  <= 1'b0;
            addr_meta_reg <= 16'h0000;
            addr_sync_reg <= 16'h0000;
            iois_meta_reg <= 1'b1;
            iois_sync_reg <= 1'b1;
        end else begin
            req_meta_reg  <= host_io_req;
            req_sync_reg  <= req_meta_reg;
            addr_meta_reg <= host_io_addr;
            addr_sync_reg <= addr_meta_reg;
            iois_meta_reg <= card_iois16_n;
            iois_sync_reg <= iois_meta_reg;
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic [7:0]  map_en_reg;
    logic [7:0]  ctrl_reg;

    wire logic       apb_access  = psel & penable;
    wire logic       pready_next = apb_access & ~pready_reg;
    wire logic       wr_fire     = apb_access & pwrite & pready_reg;
    wire logic [7:0] idx         = paddr[IDX_LSB +: IDX_W];
    wire logic       idx_ok      = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);

    cwm_win_cfg_t cfg    [NUM_WIN];
    cwm_win_res_t res    [NUM_WIN];
    logic [7:0]   rd_win [NUM_WIN];
    logic         hit_idx[NUM_WIN];

    // ************************************************************
    // Per-window registers and decoders
    // ************************************************************
    genvar w;
    generate
        for (w = 0; w < NUM_WIN; w++) begin : g_win
            logic [15:0] start_reg;
            logic [15:0] end_reg;
            logic [14:0] ofs_reg;

            wire logic sel_slo = idx_ok & (idx == IDX_START_LO[w]);
            wire logic sel_shi = idx_ok & (idx == IDX_START_HI[w]);
            wire logic sel_elo = idx_ok & (idx == IDX_END_LO[w]);
            wire logic sel_ehi = idx_ok & (idx == IDX_END_HI[w]);
            wire logic sel_olo = idx_ok & (idx == IDX_OFS_LO[w]);   // [RULE14]
            wire logic sel_ohi = idx_ok & (idx == IDX_OFS_HI[w]);   // [RULE14]

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    start_reg <= WIN_ADDR_RST;
                    end_reg   <= WIN_ADDR_RST;
                    ofs_reg   <= WIN_OFS_RST;
                end else if (wr_fire) begin
                    if (sel_slo) start_reg[7:0]  <= pwdata[7:0];    // [RULE10]
                    if (sel_shi) start_reg[15:8] <= pwdata[7:0];    // [RULE10]
                    if (sel_elo) end_reg[7:0]    <= pwdata[7:0];    // [RULE11]
                    if (sel_ehi) end_reg[15:8]   <= pwdata[7:0];    // [RULE11]
                    if (sel_olo) ofs_reg[6:0]    <= pwdata[7:1];    // [RULE12]
                    if (sel_ohi) ofs_reg[14:7]   <= pwdata[7:0];    // [RULE12]
                end
            end

            // Offset bit 0 is not stored, so an odd write cannot leak through
            assign cfg[w] = '{
                enable:     map_en_reg[w ? MAP_EN_IO1 : MAP_EN_IO0],   // [RULE15]
                auto_size:  ctrl_reg[w ? CTRL_AUTO1 : CTRL_AUTO0],     // [RULE3] [RULE6]
                size16:     ctrl_reg[w ? CTRL_SIZE1 : CTRL_SIZE0],     // [RULE2] [RULE5]
                timing:     ctrl_reg[w ? CTRL_TIMING1 : CTRL_TIMING0], // [RULE4] [RULE8]
                start_addr: start_reg,
                end_addr:   end_reg,
                offset:     {ofs_reg, 1'b0}                            // [RULE13]
            };

            assign hit_idx[w] = sel_slo | sel_shi | sel_elo | sel_ehi | sel_olo | sel_ohi;
            assign rd_win[w]  = sel_slo ? start_reg[7:0]  :
                                sel_shi ? start_reg[15:8] :
                                sel_elo ? end_reg[7:0]    :
                                sel_ehi ? end_reg[15:8]   :
                                sel_olo ? {ofs_reg[6:0], 1'b0} :
                                sel_ohi ? ofs_reg[14:7]   : 8'h00;

            cwm_window u_window (
                .cfg      (cfg[w]),
                .host_addr(addr_sync_reg),
                .iois16_n (iois_sync_reg),
                .res      (res[w])
            );
        end
    endgenerate

    // ************************************************************
    // Shared registers and read path
    // ************************************************************
    wire logic       sel_map  = idx_ok & (idx == IDX_MAP_ENABLE);
    wire logic       sel_ctrl = idx_ok & (idx == IDX_IO_CTRL);
    wire logic       mapped   = sel_map | sel_ctrl | hit_idx[0] | hit_idx[1];
    wire logic [7:0] rd_byte  = sel_map  ? map_en_reg :
                                sel_ctrl ? ctrl_reg   : (rd_win[0] | rd_win[1]);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            map_en_reg <= MAP_ENABLE_RST;
            ctrl_reg   <= IO_CTRL_RST;
        end else if (wr_fire) begin
            if (sel_map)  map_en_reg <= pwdata[7:0];
            if (sel_ctrl) ctrl_reg   <= pwdata[7:0];
        end
    end

    // One wait state: answer on the second access cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= pready_next;
            pslverr_reg <= pready_next & ~mapped;
            prdata_reg  <= (pready_next & ~pwrite & mapped) ? {24'h000000, rd_byte} : 32'h0;
        end
    end

    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;

    // ************************************************************
    // Host cycle claim and card access
    // ************************************************************
    // Window 0 wins if software lets the two ranges overlap
    wire logic         any_hit  = req_sync_reg & (res[0].hit | res[1].hit); // [RULE16]
    wire logic         pick_w1  = ~res[0].hit;
    wire cwm_win_res_t pick_res = pick_w1 ? res[1] : res[0];

    logic        claim_reg;
    logic        card_req_reg;
    logic [15:0] card_addr_reg;
    logic        wide_reg;
    logic        timing_reg;
    logic        win_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            claim_reg     <= 1'b0;
            card_req_reg  <= 1'b0;
            card_addr_reg <= 16'h0000;
            wide_reg      <= 1'b0;
            timing_reg    <= 1'b0;
            win_reg       <= 1'b0;
        end else begin
            claim_reg     <= any_hit;                                  // [RULE16]
            card_req_reg  <= any_hit;                                  // [RULE9] [RULE16]
            card_addr_reg <= any_hit ? pick_res.card_addr : 16'h0000;  // [RULE12]
            wide_reg      <= any_hit & pick_res.wide;                  // [RULE2] [RULE5]
            timing_reg    <= any_hit & pick_res.timing;                // [RULE4] [RULE8]
            win_reg       <= any_hit & pick_w1;
        end
    end

    assign host_claim     = claim_reg;
    assign card_io_req    = card_req_reg;
    assign card_io_addr   = card_addr_reg;
    assign card_io_16bit  = wide_reg;
    assign card_io_timing = timing_reg;
    assign card_io_win    = win_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_wr(logic [7:0] i);
        psel && penable && pwrite && pready && idx_ok && idx == i;
    endsequence

    sequence s_acc_wait(logic m);
        psel && penable && !pready && mapped == m;
    endsequence

    a_apb_one_wait: assert property (psel && penable && !pready |=> pready || !psel)
        else $error("APB answer late");
    a_win_start_lo: assert property (s_wr(IDX_START_LO[0]) |=> // [RULE10]
            cfg[0].start_addr[7:0] == $past(pwdata[7:0]))
        else $error("start low not stored");
    a_win_end_hi: assert property (s_wr(IDX_END_HI[1]) |=> // [RULE11]
            cfg[1].end_addr[15:8] == $past(pwdata[7:0]))
        else $error("end high not stored");
    a_ofs_index: assert property (s_wr(IDX_OFS_HI[1]) |=> // [RULE14]
            cfg[1].offset[15:8] == $past(pwdata[7:0]))
        else $error("offset high at wrong index");
    a_range_bound: assert property (card_io_req && !card_io_win |-> // [RULE9]
            $past(addr_sync_reg) >= $past(cfg[0].start_addr) &&
            $past(addr_sync_reg) <= $past(cfg[0].end_addr))
        else $error("access outside window 0");
    a_addr_xlate: assert property (card_io_req && card_io_win |-> // [RULE12]
            card_io_addr == 16'($past(addr_sync_reg) + $past(cfg[1].offset)))
        else $error("card address mistranslated");
    a_even_ofs: assert property (card_io_req |-> // [RULE13]
            card_io_addr[0] == $past(addr_sync_reg[0]))
        else $error("offset not even");
    a_rsvd_port: assert property (host_claim |-> // [RULE1]
            $past(addr_sync_reg) != RSVD_PORT_IDX && $past(addr_sync_reg) != RSVD_PORT_DATA)
        else $error("reserved port claimed");
    a_w0_fixed: assert property ( // [RULE2]
            card_io_req && !card_io_win && !$past(ctrl_reg[CTRL_AUTO0]) |->
            card_io_16bit == $past(ctrl_reg[CTRL_SIZE0]))
        else $error("window 0 fixed width wrong");
    a_w0_auto: assert property ( // [RULE3]
            card_io_req && !card_io_win && $past(ctrl_reg[CTRL_AUTO0]) |->
            card_io_16bit == !$past(iois_sync_reg))
        else $error("window 0 auto width wrong");
    a_w0_timing: assert property (card_io_req && !card_io_win |-> // [RULE4]
            card_io_timing == $past(ctrl_reg[CTRL_TIMING0]))
        else $error("window 0 timing wrong");
    a_w1_fixed: assert property ( // [RULE5]
            card_io_req && card_io_win && !$past(ctrl_reg[CTRL_AUTO1]) |->
            card_io_16bit == $past(ctrl_reg[CTRL_SIZE1]))
        else $error("window 1 fixed width wrong");
    a_w1_auto: assert property ( // [RULE6]
            card_io_req && card_io_win && $past(ctrl_reg[CTRL_AUTO1]) |->
            card_io_16bit == !$past(iois_sync_reg))
        else $error("window 1 auto width wrong");
    a_w1_timing: assert property (card_io_req && card_io_win |-> // [RULE8]
            card_io_timing == $past(ctrl_reg[CTRL_TIMING1]))
        else $error("window 1 timing wrong");
    a_map_enable: assert property (card_io_req |-> // [RULE15]
            (card_io_win ? $past(map_en_reg[MAP_EN_IO1]) : $past(map_en_reg[MAP_EN_IO0])))
        else $error("disabled window decoded");
    a_no_hit_idle: assert property (!$past(any_hit) |-> !card_io_req && !host_claim) // [RULE16]
        else $error("cycle claimed without hit");

    // ************************************************************
    // Answer shape, refusals and host path completeness
    // ************************************************************
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held high");

    a_err_unmapped: assert property (s_acc_wait(1'b0) |=> pready && pslverr)
        else $error("unmapped index not refused");

    a_err_mapped: assert property (s_acc_wait(1'b1) |=> pready && !pslverr)
        else $error("mapped index refused");

    // Zero outside the answer, so a late sample cannot look right
    a_rd_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");

    a_rd_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bytes set");

    a_wr_map_en: assert property (s_wr(IDX_MAP_ENABLE) |=> // [RULE15]
            map_en_reg == $past(pwdata[7:0]))
        else $error("map enable not stored");

    a_wr_ctrl: assert property (s_wr(IDX_IO_CTRL) |=> // [RULE2]
            ctrl_reg == $past(pwdata[7:0]))
        else $error("window control not stored");

    a_ofs_lo_even: assert property (s_wr(IDX_OFS_LO[0]) |=> // [RULE12]
            cfg[0].offset[7:0] == {$past(pwdata[7:1]), 1'b0})
        else $error("offset low not stored even");

    a_start_hi: assert property (s_wr(IDX_START_HI[0]) |=> // [RULE10]
            cfg[0].start_addr[15:8] == $past(pwdata[7:0]))
        else $error("start high not stored");

    a_end_lo: assert property (s_wr(IDX_END_LO[0]) |=> // [RULE11]
            cfg[0].end_addr[7:0] == $past(pwdata[7:0]))
        else $error("end low not stored");

    a_w0_xlate: assert property (card_io_req && !card_io_win |-> // [RULE12]
            card_io_addr == 16'($past(addr_sync_reg) + $past(cfg[0].offset)))
        else $error("window 0 address mistranslated");

    a_w1_range: assert property (card_io_req && card_io_win |-> // [RULE9]
            $past(addr_sync_reg) >= $past(cfg[1].start_addr) &&
            $past(addr_sync_reg) <= $past(cfg[1].end_addr))
        else $error("access outside window 1");

    // Overlapping ranges must still resolve to window 0
    a_w0_priority: assert property (card_io_req && card_io_win |-> !$past(res[0].hit))
        else $error("window 1 won an overlap");

    a_req_follows: assert property ($past(any_hit) |-> card_io_req && host_claim) // [RULE9]
        else $error("hit not forwarded");

    a_idle_outputs: assert property (!card_io_req |-> // [RULE16]
            card_io_addr == 16'h0000 && !card_io_16bit && !card_io_timing && !card_io_win)
        else $error("card outputs left active");

endmodule // cwm_card_io_window_mapper

// File: logic/cwm_pkg.sv
package cwm_pkg;

    // ************************************************************
    // Register bus geometry
    // ************************************************************
    localparam int unsigned APB_ADDR_W   = 12;
    localparam int unsigned APB_DATA_W   = 32;
    localparam int unsigned IDX_LSB      = 2;
    localparam int unsigned IDX_W        = 8;
    localparam int unsigned NUM_WIN      = 2;
    localparam int unsigned IO_ADDR_W    = 16;

    // ************************************************************
    // Register indexes (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0]      IDX_MAP_ENABLE = 8'h06;
    localparam logic [7:0]      IDX_IO_CTRL    = 8'h07;
    localparam logic [1:0][7:0] IDX_START_LO   = {8'h0C, 8'h08};
    localparam logic [1:0][7:0] IDX_START_HI   = {8'h0D, 8'h09};
    localparam logic [1:0][7:0] IDX_END_LO     = {8'h0E, 8'h0A};
    localparam logic [1:0][7:0] IDX_END_HI     = {8'h0F, 8'h0B};
    localparam logic [1:0][7:0] IDX_OFS_LO     = {8'h38, 8'h36};
    localparam logic [1:0][7:0] IDX_OFS_HI     = {8'h39, 8'h37};

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned     MAP_EN_IO0     = 6;
    localparam int unsigned     MAP_EN_IO1     = 7;
    localparam int unsigned     CTRL_SIZE0     = 0;
    localparam int unsigned     CTRL_AUTO0     = 1;
    localparam int unsigned     CTRL_TIMING0   = 3;
    localparam int unsigned     CTRL_SIZE1     = 4;
    localparam int unsigned     CTRL_AUTO1     = 5;
    localparam int unsigned     CTRL_TIMING1   = 7;

    // ************************************************************
    // Reset values and reserved host ports
    // ************************************************************
    localparam logic [7:0]      MAP_ENABLE_RST = 8'h00;
    localparam logic [7:0]      IO_CTRL_RST    = 8'h00;
    localparam logic [15:0]     WIN_ADDR_RST   = 16'h0000;
    localparam logic [14:0]     WIN_OFS_RST    = 15'h0000;
    localparam logic [15:0]     RSVD_PORT_IDX  = 16'h03E0;
    localparam logic [15:0]     RSVD_PORT_DATA = 16'h03E1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic        enable;
        logic        auto_size;
        logic        size16;
        logic        timing;
        logic [15:0] start_addr;
        logic [15:0] end_addr;
        logic [15:0] offset;
    } cwm_win_cfg_t;

    typedef struct packed {
        logic        hit;
        logic        wide;
        logic        timing;
        logic [15:0] card_addr;
    } cwm_win_res_t;

endpackage

// File: logic/cwm_window.sv
`timescale 1ns/1ps
module cwm_window
    import cwm_pkg::*;
(
    input  wire cwm_win_cfg_t cfg,
    input  wire logic [15:0]  host_addr,
    input  wire logic         iois16_n,
    output cwm_win_res_t      res
);

    // ************************************************************
    // Range compare and translation
    // ************************************************************
    wire logic above_start = host_addr >= cfg.start_addr;   // [RULE9] [RULE10]
    wire logic below_end   = host_addr <= cfg.end_addr;     // [RULE9] [RULE11]
    // Guard keeps the adapter's own ports out even if misprogrammed
    wire logic rsvd_port   = (host_addr == RSVD_PORT_IDX) |
                             (host_addr == RSVD_PORT_DATA); // [RULE1]

    // One driver for the whole result word
    assign res = '{
        hit:       cfg.enable & above_start & below_end & ~rsvd_port, // [RULE9] [RULE15]
        wide:      cfg.auto_size ? ~iois16_n : cfg.size16, // [RULE2] [RULE3] [RULE5] [RULE6]
        timing:    cfg.timing,                                      // [RULE4] [RULE8]
        card_addr: 16'(host_addr + cfg.offset)                      // [RULE12]
    };

endmodule // cwm_window

// File: tb/cwm_host_card_model.sv
`timescale 1ns/1ps
// ************************************************************
// Host master and card stand-in
// ************************************************************
module cwm_host_card_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        cyc_go,
    input  wire logic [15:0] cyc_addr,
    input  wire logic        card_wide,
    output logic             host_io_req,
    output logic      [15:0] host_io_addr,
    output logic             card_iois16_n
);
    // Idle bus shows the inverted old address, so a stale match cannot pass
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            host_io_req   <= 1'b0;
            host_io_addr  <= 16'hFFFF;
            card_iois16_n <= 1'b1;
        end else begin
            host_io_req   <= cyc_go;
            host_io_addr  <= cyc_go ? cyc_addr : ~host_io_addr;
            // Pulled high unless the addressed card asks for 16 bits
            card_iois16_n <= ~(cyc_go & card_wide);
        end
    end
endmodule // cwm_host_card_model

// File: tb/tb_cwm_card_io_window_mapper.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_cwm_card_io_window_mapper
    import cwm_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic        cyc_go  = 1'b0;
    logic [15:0] cyc_addr = 16'h0000;
    logic        card_wide = 1'b0;
    logic        host_io_req, card_iois16_n, host_claim, card_io_req;
    logic [15:0] host_io_addr, card_io_addr;
    logic        card_io_16bit, card_io_timing, card_io_win;
    int          errors      = 0;
    int          check_count = 0;
    int          cycles      = 0;

    always #10 sys_clk = ~sys_clk;

    cwm_card_io_window_mapper i_cwm_card_io_window_mapper (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_io_req(host_io_req),
        .host_io_addr(host_io_addr), .card_iois16_n(card_iois16_n),
        .host_claim(host_claim), .card_io_req(card_io_req),
        .card_io_addr(card_io_addr), .card_io_16bit(card_io_16bit),
        .card_io_timing(card_io_timing), .card_io_win(card_io_win));

    cwm_host_card_model i_cwm_host_card_model (
        .sys_clk(sys_clk), .resetn(resetn), .cyc_go(cyc_go), .cyc_addr(cyc_addr),
        .card_wide(card_wide), .host_io_req(host_io_req),
        .host_io_addr(host_io_addr), .card_iois16_n(card_iois16_n));

    // ************************************************************
    // Bus and port helpers
    // ************************************************************
    task automatic stop_test();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    // Values read right after the edge are the ones the edge sampled
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        // No local limit; the bench timeout catches a silent slave
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 8'h00, rd, err);
        `CHK("prdata", {24'h000000, exp}, rd)
        `CHK("pslverr", exp_err, err)
    endtask

    task automatic prog(input int w, input logic [15:0] s, input logic [15:0] e,
                        input logic [15:0] o);
        wr(IDX_START_LO[w], s[7:0]);
        wr(IDX_START_HI[w], s[15:8]);
        wr(IDX_END_LO[w], e[7:0]);
        wr(IDX_END_HI[w], e[15:8]);
        wr(IDX_OFS_LO[w], o[7:0]);
        wr(IDX_OFS_HI[w], o[15:8]);
    endtask

    task automatic io_chk(input logic [15:0] a, input logic w, input logic hit,
                          input logic [15:0] ca, input logic wide, input logic tm,
                          input logic win);
        cyc_go   <= 1'b1;
        cyc_addr <= a;
        card_wide <= w;
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("host_claim", hit, host_claim)
        `CHK("card_io_req", hit, card_io_req)
        `CHK("card_io_addr", ca, card_io_addr)
        `CHK("card_io_16bit", wide, card_io_16bit)
        `CHK("card_io_timing", tm, card_io_timing)
        `CHK("card_io_win", win, card_io_win)
        @(posedge sys_clk);
        cyc_go <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("claim after end", 1'b0, host_claim)
        @(posedge sys_clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        rd_chk(IDX_IO_CTRL, IO_CTRL_RST, 1'b0);
        rd_chk(IDX_MAP_ENABLE, MAP_ENABLE_RST, 1'b0);
        prog(1, 16'hA55A, 16'hC33C, 16'h9634);
        rd_chk(IDX_START_LO[1], 8'h5A, 1'b0);
        rd_chk(IDX_START_HI[1], 8'hA5, 1'b0);
        rd_chk(IDX_END_LO[1], 8'h3C, 1'b0);
        rd_chk(IDX_END_HI[1], 8'hC3, 1'b0);
        rd_chk(IDX_OFS_LO[1], 8'h34, 1'b0);
        rd_chk(IDX_OFS_HI[1], 8'h96, 1'b0);
        rd_chk(8'h50, 8'h00, 1'b1);
    endtask

    // Bounds straddle a byte carry; offset wraps past 16 bits
    task automatic t_range();
        prog(0, 16'h12FE, 16'h1401, 16'hF002);
        io_chk(16'h12FE, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
        wr(IDX_MAP_ENABLE, 8'h40);
        io_chk(16'h12FD, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
        io_chk(16'h12FE, 1'b0, 1'b1, 16'h0300, 1'b0, 1'b0, 1'b0);
        io_chk(16'h1401, 1'b0, 1'b1, 16'h0403, 1'b0, 1'b0, 1'b0);
        io_chk(16'h1402, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
    endtask

    // Every size, auto-size and timing choice, card narrow and wide
    task automatic t_modes();
        logic [2:0] c;
        prog(0, 16'h0100, 16'h010F, 16'h0000);
        prog(1, 16'h0170, 16'h0177, 16'h0010);
        wr(IDX_MAP_ENABLE, 8'hC0);
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(IDX_IO_CTRL, {c[2], 1'b0, c[1], c[0], c[2], 1'b0, c[1], c[0]});
            for (int w = 0; w < 2; w++) begin
                io_chk(16'h0104, 1'(w), 1'b1, 16'h0104, c[1] ? 1'(w) : c[0],
                       c[2], 1'b0);
                io_chk(16'h0172, 1'(w), 1'b1, 16'h0182, c[1] ? 1'(w) : c[0],
                       c[2], 1'b1);
            end
        end
        wr(IDX_MAP_ENABLE, 8'h40);
        io_chk(16'h0172, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_range();
        t_modes();
        stop_test();
    end
endmodule // tb_cwm_card_io_window_mapper
